// ===== hdl/scrt_prescale.sv
`timescale 1ns/100ps
`default_nettype none
module scrt_prescale #(
  parameter int W = scrt_pkg::DIV_W
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // control
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_div,
  // tick out
  output var  logic         o_tick
);
  logic [W-1:0] cnt_q;
  wire  [W-1:0] last = i_div - {{(W-1){1'b0}}, 1'b1};
  wire          wrap = cnt_q >= last;

  // >= so a smaller divider taken mid-count still wraps
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_q  <= (!i_run || wrap) ? '0 : cnt_q + {{(W-1){1'b0}}, 1'b1};
      o_tick <= i_run & wrap;
    end
  end

  tick_space_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_tick |=> !o_tick) else $error("prescaler ticks back to back");
endmodule
`default_nettype wire

// ===== hdl/scrt_sync_edge.sv
`timescale 1ns/100ps
`default_nettype none
module scrt_sync_edge (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // pin and its view
  input  wire logic i_pin,
  output var  logic o_level,
  output var  logic o_fall
);
  logic meta_q;
  logic prev_q;

  // pins idle high, so reset high avoids a false edge
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q  <= 1'b1;
      o_level <= 1'b1;
      prev_q  <= 1'b1;
      o_fall  <= 1'b0;
    end else begin
      meta_q  <= i_pin;
      o_level <= meta_q;
      prev_q  <= o_level;
      o_fall  <= prev_q & ~o_level;
    end
  end

  fall_once_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_fall |=> !o_fall) else $error("fall pulse longer than one cycle");
endmodule
`default_nettype wire

// ===== hdl/scrt_timer.sv
`timescale 1ns/100ps
`default_nettype none
module scrt_timer (
  // clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_resetn,
  // avalon-mm slave
  input  wire logic [scrt_pkg::ADDR_W-1:0]  i_avs_address,
  input  wire logic                         i_avs_read,
  input  wire logic                         i_avs_write,
  input  wire logic [scrt_pkg::DATA_W-1:0]  i_avs_writedata,
  input  wire logic [scrt_pkg::BE_W-1:0]    i_avs_byteenable,
  output var  logic [scrt_pkg::DATA_W-1:0]  o_avs_readdata,
  output var  logic                         o_avs_waitrequest,
  // pins
  input  wire logic                         i_external_trigger_pin,
  input  wire logic                         i_count_input_pin,
  output var  logic                         o_count_input_pin,
  output var  logic                         o_count_input_pin_oe,
  // serial port clocking
  input  wire logic                         i_other_timer_ovf,
  output var  logic                         o_rx_shift_tick,
  output var  logic                         o_tx_shift_tick,
  // interrupt request flags
  output var  logic                         o_overflow_flag,
  output var  logic                         o_external_flag
);
  import scrt_pkg::*;

  // register state
  logic [5:0]  cfg_q;
  logic        oe_q;
  logic        down_count_enable_q;
  logic        fast_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] rel_q;
  logic [15:0] rel_d;
  logic        tf_d;
  logic        exf_d;

  // pin views
  logic        trig_level;
  logic        trig_fall;
  logic        cin_level;
  logic        cin_fall;
  logic        pre_tick;

  // bus decode
  wire [7:0] idx     = i_avs_address[ADDR_W-1:IDX_LSB];
  wire [7:0] wdata   = i_avs_writedata[7:0];
  wire       req     = i_avs_read | i_avs_write;
  wire       take    = req & o_avs_waitrequest;
  wire       commit  = i_avs_write & ~o_avs_waitrequest;
  wire       wr_ok   = commit & i_avs_byteenable[0];
  wire       wr_ctl  = wr_ok & (idx == IDX_CTL);
  wire       wr_mode = wr_ok & (idx == IDX_MODE);
  wire       wr_clk  = wr_ok & (idx == IDX_CLK);
  wire       wr_rl   = wr_ok & (idx == IDX_RL);
  wire       wr_rh   = wr_ok & (idx == IDX_RH);
  wire       wr_cl   = wr_ok & (idx == IDX_CL);
  wire       wr_ch   = wr_ok & (idx == IDX_CH);
  wire       cnt_wr  = wr_cl | wr_ch;
  wire       rel_wr  = wr_rl | wr_rh;

  // control fields
  wire run         = cfg_q[CTL_RUN];
  wire src_pin     = cfg_q[CTL_SRC];
  wire ext_en      = cfg_q[CTL_EXEN];
  wire rx_sel      = cfg_q[CTL_RXS];
  wire tx_sel      = cfg_q[CTL_TXS];
  wire baud        = rx_sel | tx_sel;
  wire fast_base   = baud | oe_q;
  wire capture_md  = cfg_q[CTL_CPRL] & ~baud;
  wire reload_md   = ~capture_md;
  wire updown_md   = reload_md & down_count_enable_q & ~baud;
  wire down_dir    = updown_md & ~trig_level;
  wire ext_ev      = ext_en & trig_fall;

  // read mux, reserved bits read zero
  wire [7:0] ctl_rd  = {o_overflow_flag, o_external_flag, cfg_q};
  wire [7:0] mode_rd = {6'h00, oe_q, down_count_enable_q};
  wire [7:0] clk_rd  = {2'h0, fast_q, 5'h00};
  wire [7:0] rd_byte =
    (idx == IDX_CTL)  ? ctl_rd        :
    (idx == IDX_MODE) ? mode_rd       :
    (idx == IDX_CLK)  ? clk_rd        :
    (idx == IDX_RL)   ? rel_q[7:0]    :
    (idx == IDX_RH)   ? rel_q[15:8]   :
    (idx == IDX_CL)   ? count_q[7:0]  :
    (idx == IDX_CH)   ? count_q[15:8] : 8'h00;

  // timebase: /2 in baud or clock-out, else /12 or /4
  wire [DIV_W-1:0] div_sel =
    fast_base ? DIV_BAUD : (fast_q ? DIV_FAST : DIV_SLOW);

  // the pin cannot be counted while this block drives it
  wire pin_tick = cin_fall & ~oe_q;
  wire tick     = run & (src_pin ? pin_tick : pre_tick);

  // events
  wire at_max    = count_q == COUNT_MAX;
  wire ovf       = tick & ~down_dir & at_max;
  wire unf       = tick & down_dir & (count_q == rel_q);
  wire wrap_ev   = ovf | unf;
  wire force_rl  = reload_md & ~baud & ~updown_md & ext_ev;
  wire capture   = capture_md & ext_ev;
  wire tf_set    = wrap_ev & ~baud & ~oe_q;
  wire exf_tog   = updown_md & wrap_ev;
  wire exf_set   = ext_ev & (capture | force_rl | baud | oe_q);

  scrt_sync_edge u_trig (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_pin    (i_external_trigger_pin),
    .o_level  (trig_level),
    .o_fall   (trig_fall)
  );

  scrt_sync_edge u_cin (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_pin    (i_count_input_pin),
    .o_level  (cin_level),
    .o_fall   (cin_fall)
  );

  scrt_prescale #(
    .W (DIV_W)
  ) u_pre (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_run    (run & ~src_pin),
    .i_div    (div_sel),
    .o_tick   (pre_tick)
  );

  // count next value; one 16-bit register throughout
  always_comb begin
    count_d = count_q;
    if (force_rl) begin
      count_d = rel_q;
    end else if (ovf) begin
      count_d = reload_md ? rel_q : COUNT_RST;
    end else if (unf) begin
      count_d = COUNT_MAX;
    end else if (tick) begin
      count_d = down_dir ? count_q - COUNT_ONE : count_q + COUNT_ONE;
    end
    if (wr_cl) begin
      count_d[7:0] = wdata;
    end
    if (wr_ch) begin
      count_d[15:8] = wdata;
    end
  end

  // capture overrides a colliding software byte write
  always_comb begin
    rel_d = rel_q;
    if (wr_rl) begin
      rel_d[7:0] = wdata;
    end
    if (wr_rh) begin
      rel_d[15:8] = wdata;
    end
    if (capture) begin
      rel_d = count_q;
    end
  end

  // hardware set or toggle wins over a software write
  always_comb begin
    tf_d  = wr_ctl ? wdata[CTL_OVF] : o_overflow_flag;
    exf_d = wr_ctl ? wdata[CTL_EXF] : o_external_flag;
    if (tf_set) begin
      tf_d = 1'b1;
    end
    if (exf_tog) begin
      exf_d = ~o_external_flag;
    end else if (exf_set) begin
      exf_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= '0;
    end else begin
      o_avs_waitrequest <= ~take;
      if (take) begin
        o_avs_readdata <= {24'h000000, rd_byte};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_q  <= CFG_RST;
      oe_q   <= 1'b0;
      down_count_enable_q <= 1'b0;
      fast_q <= 1'b0;
    end else begin
      if (wr_ctl) begin
        cfg_q <= wdata[5:0];
      end
      if (wr_mode) begin
        oe_q   <= wdata[MODE_OE];
        down_count_enable_q <= wdata[MODE_DOWN_COUNT_ENABLE];
      end
      if (wr_clk) begin
        fast_q <= wdata[CLK_DIV];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_q         <= COUNT_RST;
      rel_q           <= RL_RST;
      o_overflow_flag <= 1'b0;
      o_external_flag <= 1'b0;
    end else begin
      count_q         <= count_d;
      rel_q           <= rel_d;
      o_overflow_flag <= tf_d;
      o_external_flag <= exf_d;
    end
  end

  // pin drive and serial clock routing
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_count_input_pin    <= 1'b0;
      o_count_input_pin_oe <= 1'b0;
      o_rx_shift_tick      <= 1'b0;
      o_tx_shift_tick      <= 1'b0;
    end else begin
      o_count_input_pin_oe <= oe_q;
      if (oe_q & ovf) begin
        o_count_input_pin <= ~o_count_input_pin;
      end
      o_rx_shift_tick <= rx_sel ? ovf : i_other_timer_ovf;
      o_tx_shift_tick <= tx_sel ? ovf : i_other_timer_ovf;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_req_wait;
    req && o_avs_waitrequest;
  endsequence

  sequence s_ack;
    !o_avs_waitrequest;
  endsequence

  bus_ack_a: assert property (
    s_req_wait |-> ##1 s_ack) else $error("no answer after one cycle");

  run_hold_a: assert property (
    !run && !cnt_wr && !force_rl |=> $stable(count_q)
  ) else $error("count moved while stopped");

  ovf_flag_a: assert property (
    tf_set |=> o_overflow_flag) else $error("overflow flag not set");

  reload_load_a: assert property (
    ovf && reload_md && !cnt_wr |=> count_q == $past(rel_q)
  ) else $error("auto-reload missing");

  capture_cp_a: assert property (
    capture |=> rel_q == $past(count_q)
  ) else $error("capture missed count");

  under_ld_a: assert property (
    unf && !cnt_wr |=> count_q == COUNT_MAX
  ) else $error("underflow did not load max");

  exf_tog_a: assert property (
    exf_tog |=> o_external_flag != $past(o_external_flag)
  ) else $error("external flag not toggled");

  baud_noflag_a: assert property (
    baud && !o_overflow_flag && !wr_ctl |=> !o_overflow_flag
  ) else $error("overflow flag set in baud mode");

  clk_out_a: assert property (
    oe_q && ovf |=> o_count_input_pin != $past(o_count_input_pin)
  ) else $error("clock out did not toggle");

  step_up_a: assert property (
    tick && !down_dir && !at_max && !cnt_wr && !force_rl
    |=> count_q == $past(count_q) + COUNT_ONE
  ) else $error("count did not step");

  shift_route_a: assert property (
    tx_sel && ovf |=> o_tx_shift_tick ##1 !o_tx_shift_tick
  ) else $error("shift tick not routed");

  force_rl_a: assert property (
    force_rl && !cnt_wr |=> count_q == $past(rel_q)
  ) else $error("forced reload missing");

  exf_set_a: assert property (
    exf_set && !exf_tog |=> o_external_flag
  ) else $error("external flag not set");

  pin_free_a: assert property (
    !oe_q |=> !o_count_input_pin_oe
  ) else $error("count pin driven while disabled");

  flag_keep_a: assert property (
    o_overflow_flag && !wr_ctl |=> o_overflow_flag
  ) else $error("overflow flag dropped without a write");
endmodule
`default_nettype wire

// ===== inc/scrt_pkg.sv
`default_nettype none
package scrt_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTL  = 8'hC8;
  localparam logic [7:0] IDX_MODE = 8'hC9;
  localparam logic [7:0] IDX_CLK  = 8'h8E;
  localparam logic [7:0] IDX_RL   = 8'hCA;
  localparam logic [7:0] IDX_RH   = 8'hCB;
  localparam logic [7:0] IDX_CL   = 8'hCC;
  localparam logic [7:0] IDX_CH   = 8'hCD;
  localparam int         ADDR_W   = 10;
  localparam int         DATA_W   = 32;
  localparam int         BE_W     = 4;
  localparam int         IDX_LSB  = 2;
  // timer control register fields
  localparam int CTL_OVF  = 7;
  localparam int CTL_EXF  = 6;
  localparam int CTL_RXS  = 5;
  localparam int CTL_TXS  = 4;
  localparam int CTL_EXEN = 3;
  localparam int CTL_RUN  = 2;
  localparam int CTL_SRC  = 1;
  localparam int CTL_CPRL = 0;
  // timer mode register fields
  localparam int MODE_OE   = 1;
  localparam int MODE_DOWN_COUNT_ENABLE = 0;
  // clock control register field
  localparam int CLK_DIV = 5;
  // reset values and count constants
  localparam logic [5:0]  CFG_RST   = 6'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] RL_RST    = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  // oscillator cycles per tick
  localparam int         DIV_W    = 4;
  localparam logic [3:0] DIV_SLOW = 4'hC;
  localparam logic [3:0] DIV_FAST = 4'h4;
  localparam logic [3:0] DIV_BAUD = 4'h2;
endpackage
`default_nettype wire

// ===== test/scrt_partner.sv
`timescale 1ns/100ps
`default_nettype none
module scrt_partner (
  // clock
  input  wire logic i_clk,
  // from the timer
  input  wire logic i_pin_out,
  input  wire logic i_pin_oe,
  input  wire logic i_rx_tick,
  input  wire logic i_tx_tick,
  // to the timer
  output var  logic o_trig,
  output var  logic o_count_pin,
  output var  logic o_other_ovf
);
  logic drv_q  = 1'b1;
  logic last_q = 1'b0;
  int   div_q  = 0;
  int   rx_n   = 0;
  int   tx_n   = 0;
  int   oth_n  = 0;
  int   tog_n  = 0;
  // pull-up on the pin: released means high, never a stale level
  assign o_count_pin = i_pin_oe ? i_pin_out : drv_q;
  initial begin
    o_trig = 1'b1;
    o_other_ovf = 1'b0;
  end
  // other timer overflows every 7 cycles; tallies of what comes back
  always @(posedge i_clk) begin
    div_q <= (div_q == 6) ? 0 : div_q + 1;
    o_other_ovf <= (div_q == 6);
    oth_n <= oth_n + int'(o_other_ovf);
    rx_n <= rx_n + int'(i_rx_tick);
    tx_n <= tx_n + int'(i_tx_tick);
    last_q <= i_pin_out;
    if (i_pin_oe && i_pin_out !== last_q) begin
      tog_n <= tog_n + 1;
    end
  end
  // low held past the synchroniser so each fall counts once
  task automatic fall(input bit on_trig);
    @(posedge i_clk);
    if (on_trig) begin
      o_trig <= 1'b0;
    end else begin
      drv_q <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    o_trig <= 1'b1;
    drv_q <= 1'b1;
    repeat (6) @(posedge i_clk);
  endtask
  task automatic level(input logic v);
    @(posedge i_clk);
    o_trig <= v;
  endtask
endmodule
`default_nettype wire

// ===== test/sixteen_bit_capture_reload_timer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sixteen_bit_capture_reload_timer_tb;
  import scrt_pkg::*;
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic              rd_en = 1'b0;
  logic              wr_en = 1'b0;
  logic [DATA_W-1:0] wdat = '0;
  logic [BE_W-1:0]   be = 4'hF;
  wire logic [DATA_W-1:0] rdat;
  wire logic         wreq, trig, cpin, pin_o, pin_oe, oth, rx, tx, ovf, exf;
  int                fails = 0;
  int                check_count = 0;
  logic [15:0]       v;
  logic [7:0]        x;
  int                a, b, c;

  always #5 clk = ~clk;

  scrt_timer dut (.i_clk(clk), .i_resetn(resetn), .i_avs_address(adr),
    .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdat),
    .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_external_trigger_pin(trig), .i_count_input_pin(cpin),
    .o_count_input_pin(pin_o), .o_count_input_pin_oe(pin_oe),
    .i_other_timer_ovf(oth), .o_rx_shift_tick(rx), .o_tx_shift_tick(tx),
    .o_overflow_flag(ovf), .o_external_flag(exf));

  scrt_partner p (.i_clk(clk), .i_pin_out(pin_o), .i_pin_oe(pin_oe),
    .i_rx_tick(rx), .i_tx_tick(tx), .o_trig(trig), .o_count_pin(cpin),
    .o_other_ovf(oth));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic flg(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic rng(input logic [31:0] got, input int lo, input int hi);
    flg(got >= lo && got <= hi, 1'b1);
  endtask
  // request held until waitrequest is sampled low, released at that edge
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    adr <= {i, 2'b00};
    wr_en <= w;
    rd_en <= !w;
    wdat <= {24'h000000, d};
    @(posedge clk);
    // only the watchdog ends a wait that never sees an answer
    while (wreq !== 1'b0) begin
      @(posedge clk);
    end
    x = rdat[7:0];
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk({8'h00, x}, {8'h00, e});
  endtask
  // byte pairs are not latched, so only read them while stopped
  task automatic rd16(input logic [7:0] i);
    bus(1'b0, i, 8'h00);
    v[7:0] = x;
    bus(1'b0, i + 8'h01, 8'h00);
    v[15:8] = x;
  endtask
  task automatic wr16(input logic [7:0] i, input logic [15:0] d);
    bus(1'b1, i, d[7:0]);
    bus(1'b1, i + 8'h01, d[15:8]);
  endtask
  task automatic run_for(input logic [7:0] ctl, input int n);
    bus(1'b1, IDX_CTL, ctl);
    repeat (n) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict;
  end

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdc(IDX_RL, 8'h00);
    rdc(IDX_CH, 8'h00);
    bus(1'b1, 8'h10, 8'h5A);
    rdc(8'h10, 8'h00);
    wr16(IDX_RL, 16'hA55A);
    rd16(IDX_RL);
    chk(v, 16'hA55A);
    wr16(IDX_CL, 16'h3CC3);
    rd16(IDX_CL);
    chk(v, 16'h3CC3);
    // lane 0 disabled: the byte write must be dropped
    be <= 4'hE;
    bus(1'b1, IDX_CL, 8'h77);
    be <= 4'hF;
    rdc(IDX_CL, 8'hC3);
    $display("test registers finished");
    // slow then fast timebase
    for (a = 0; a < 2; a++) begin
      bus(1'b1, IDX_CLK, a ? 8'h20 : 8'h00);
      wr16(IDX_CL, 16'h0000);
      run_for(8'h04, 120);
      bus(1'b1, IDX_CTL, 8'h00);
      rd16(IDX_CL);
      rng(v, a ? 29 : 9, a ? 33 : 12);
      b = int'(v);
      rd16(IDX_CL);
      chk(v, 16'(b));
    end
    $display("test timebase finished");
    wr16(IDX_RL, 16'h1234);
    wr16(IDX_CL, 16'hFFFE);
    run_for(8'h04, 40);
    flg(ovf, 1'b1);
    rdc(IDX_CTL, 8'h84);
    bus(1'b1, IDX_CTL, 8'h00);
    flg(ovf, 1'b0);
    rd16(IDX_CL);
    rng(v, 16'h1234, 16'h1240);
    $display("test reload finished");
    wr16(IDX_CL, 16'h5A3C);
    bus(1'b1, IDX_CTL, 8'h09);
    p.fall(1'b1);
    rd16(IDX_RL);
    chk(v, 16'h5A3C);
    flg(exf, 1'b1);
    rdc(IDX_CTL, 8'h49);
    wr16(IDX_RL, 16'h1111);
    for (a = 0; a < 2; a++) begin
      wr16(IDX_CL, 16'h2222);
      bus(1'b1, IDX_CTL, a ? 8'h08 : 8'h00);
      flg(exf, 1'b0);
      p.fall(1'b1);
      rd16(IDX_CL);
      chk(v, a ? 16'h1111 : 16'h2222);
    end
    $display("test trigger finished");
    bus(1'b1, IDX_CTL, 8'h00);
    bus(1'b1, IDX_MODE, 8'h01);
    p.level(1'b0);
    wr16(IDX_RL, 16'h0010);
    wr16(IDX_CL, 16'h0012);
    run_for(8'h04, 40);
    flg(exf, 1'b1);
    flg(ovf, 1'b1);
    bus(1'b1, IDX_CTL, 8'h00);
    rdc(IDX_CH, 8'hFF);
    p.level(1'b1);
    bus(1'b1, IDX_MODE, 8'h00);
    $display("test down count finished");
    // reload bytes only touched while stopped
    wr16(IDX_RL, 16'hFFF0);
    wr16(IDX_CL, 16'hFFF0);
    a = p.rx_n;
    b = p.tx_n;
    c = p.oth_n;
    run_for(8'h25, 320);
    flg(ovf, 1'b0);
    bus(1'b1, IDX_CTL, 8'h00);
    rng(p.rx_n - a, 9, 11);
    rng(p.tx_n - b - (p.oth_n - c) + 1, 0, 2);
    rd16(IDX_CL);
    rng(v, 16'hFFF0, 16'hFFFF);
    $display("test baud finished");
    flg(pin_oe, 1'b0);
    wr16(IDX_RL, 16'hFFF8);
    wr16(IDX_CL, 16'hFFF8);
    bus(1'b1, IDX_MODE, 8'h02);
    a = p.tog_n;
    b = p.tx_n;
    run_for(8'h14, 320);
    flg(pin_oe, 1'b1);
    flg(ovf, 1'b0);
    bus(1'b1, IDX_CTL, 8'h00);
    // tally at once: later tx pulses come from the other timer again
    rng(p.tog_n - a, 19, 21);
    rng(p.tx_n - b - (p.tog_n - a) + 1, 0, 2);
    bus(1'b1, IDX_MODE, 8'h00);
    $display("test clock out finished");
    wr16(IDX_CL, 16'h0000);
    bus(1'b1, IDX_CTL, 8'h06);
    repeat (3) p.fall(1'b0);
    bus(1'b1, IDX_CTL, 8'h00);
    rd16(IDX_CL);
    chk(v, 16'h0003);
    $display("test count pin finished");
    print_verdict;
  end
endmodule
`default_nettype wire
